//--- hdl/ercc_pkg.sv
package ercc_pkg;
   localparam logic [15:0] RX_CFG_OFFSET  = 16'h0102;
   localparam logic [15:0] RX_EVT_OFFSET  = 16'h0124;
   localparam logic [15:0] ISQ_OFFSET     = 16'h0120;
   localparam logic [15:0] RX_CFG_RESET   = 16'h0003;
   localparam logic [5:0]  RX_CFG_ID      = 6'h03;
   localparam logic [5:0]  RX_EVT_ID      = 6'h04;
   localparam logic [15:0] RX_EVT_RESET   = 16'h0004;
   localparam int          CFG_SKIP       = 6;
   localparam int          CFG_STREAM     = 7;
   localparam int          CFG_GOOD_IE    = 8;
   localparam int          CFG_DMA_ONLY   = 9;
   localparam int          CFG_AUTO_DMA   = 10;
   localparam int          CFG_KEEP_CRC   = 11;
   localparam int          CFG_CRC_IE     = 12;
   localparam int          CFG_SHORT_IE   = 13;
   localparam int          CFG_OVER_IE    = 14;
   localparam int          EVT_GOOD       = 8;
   localparam int          EVT_CRC        = 12;
   localparam int          EVT_SHORT      = 13;
   localparam int          EVT_OVER       = 14;
   localparam logic [10:0] MIN_FRAME      = 11'd64;
   localparam logic [10:0] DISCARD_FRAME  = 11'd8;
   localparam logic [10:0] MAX_FRAME      = 11'd1518;
   localparam logic [10:0] CRC_BYTES      = 11'd4;

   typedef struct packed {
      logic        done;
      logic [10:0] length;
      logic        crc_bad;
      logic        back_to_back;
      logic        addr_pass;
      logic        switch_cond;
   } ercc_frame_t;

   typedef struct packed {
      logic        deliver;
      logic        drop;
      logic [10:0] length;
      logic        keep_crc;
      logic        use_dma;
      logic        use_stream;
   } ercc_route_t;
endpackage

//--- hdl/ercc_rx_cfg.sv
// Operation
// [R01] configuration low six bits always read 000011
// [R02] writing skip bit deletes last committed frame from buffer
// [R03] skip acts once per written one
// [R04] host avoids skip while dma-only bit set
// [R05] stream enable uses stream mode for back-to-back filtered frames
// [R06] host sets stream only with auto dma or dma-only
// [R07] good-frame enable raises interrupt for error-free frames
// [R08] no good-frame interrupt when frame goes through dma
// [R09] dma-only bit sends every frame through dma
// [R10] auto dma switches to dma when switch conditions hold
// [R11] dma-only wins over auto dma
// [R12] keep-crc stores crc and counts four bytes in length
// [R13] without keep-crc, crc left out of data and length
// [R14] crc-error enable raises interrupt on bad crc
// [R15] short-frame enable raises interrupt below 64 bytes
// [R16] frames below 8 bytes always discarded
// [R17] oversize enable raises interrupt above 1518 bytes
// [R18] oversize interrupt regardless of crc result
// [R19] reset value 0x0003 without eeprom
// [R20] eeprom may supply initial configuration after reset
// [R21] enabled event sets flags, shows in status queue, raises irq
// [R22] reading event register clears all its bits
// [R23] writes to identifier bits ignored
`timescale 1ns/1ns
module ercc_rx_cfg
   import ercc_pkg::*;
(
   // clock and reset
   input  wire logic                  mclk,
   input  wire logic                  rst_n,
   // host register port
   input  wire logic [15:0]           reg_addr,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   input  wire logic [15:0]           reg_wdata,
   output logic [15:0]                reg_rdata,
   // eeprom preload
   input  wire logic                  eeprom_load,
   input  wire logic [15:0]           eeprom_cfg,
   // frame end report from receiver
   input  wire ercc_pkg::ercc_frame_t frame,
   // outputs to buffer and host
   output ercc_pkg::ercc_route_t      route,
   output logic                       skip_frame,
   output logic                       irq
);
   import ercc_pkg::*;

   logic [15:0] cfg;
   logic [15:0] evt;
   logic [15:0] interrupt_status_queue;
   logic        load_s1;
   logic        load_s2;
   logic        load_d;
   logic        dma_sel;
   logic        short_drop;
   logic        good;
   logic [15:0] next_evt;
   logic [15:0] raised;

   // eeprom load strobe comes from outside logic: sync then edge
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         load_s1 <= 1'b0;
         load_s2 <= 1'b0;
         load_d  <= 1'b0;
      end else begin
         load_s1 <= eeprom_load;
         load_s2 <= load_s1;
         load_d  <= load_s2;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cfg <= RX_CFG_RESET; // R19
      end else if (reg_wr && reg_addr == RX_CFG_OFFSET) begin
         cfg <= {reg_wdata[15:6], RX_CFG_ID}; // R23 R01
      end else if (load_s2 && !load_d) begin
         cfg <= {eeprom_cfg[15:7], 1'b0, RX_CFG_ID}; // R20
      end else begin
         cfg[CFG_SKIP] <= 1'b0; // R03
      end
   end

   // skip pulses one cycle per written one
   always_ff @(posedge mclk) begin
      if (!rst_n)
         skip_frame <= 1'b0;
      else
         skip_frame <= reg_wr && reg_addr == RX_CFG_OFFSET
                       && reg_wdata[CFG_SKIP]; // R02 R03
   end

   always_comb begin
      dma_sel    = cfg[CFG_DMA_ONLY] // R09 R11
                   || (cfg[CFG_AUTO_DMA] && frame.switch_cond); // R10
      short_drop = frame.length < DISCARD_FRAME; // R16
      good       = !frame.crc_bad && frame.length >= MIN_FRAME
                   && frame.length <= MAX_FRAME;
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         route <= '0;
      end else begin
         route.deliver    <= frame.done && !short_drop;
         route.drop       <= frame.done && short_drop; // R16
         route.keep_crc   <= cfg[CFG_KEEP_CRC]; // R12 R13
         route.length     <= cfg[CFG_KEEP_CRC] ? frame.length // R12
                             : frame.length - CRC_BYTES; // R13
         route.use_dma    <= dma_sel;
         route.use_stream <= cfg[CFG_STREAM] && frame.back_to_back
                             && frame.addr_pass; // R05
      end
   end

   always_comb begin
      raised = '0;
      if (frame.done && !short_drop) begin
         raised[EVT_GOOD]  = good && !dma_sel; // R08
         raised[EVT_CRC]   = frame.crc_bad;
         raised[EVT_SHORT] = frame.length < MIN_FRAME;
         raised[EVT_OVER]  = frame.length > MAX_FRAME; // R18
      end
      next_evt = evt;
      if (reg_rd && reg_addr == RX_EVT_OFFSET)
         next_evt = {10'h000, RX_EVT_ID}; // R22
      if (frame.done && !short_drop)
         next_evt = {next_evt[15:6] | raised[15:6], RX_EVT_ID};
   end

   always_ff @(posedge mclk) begin
      if (!rst_n)
         evt <= RX_EVT_RESET;
      else
         evt <= next_evt;
   end

   // status queue and irq follow enabled events
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         interrupt_status_queue <= '0;
         irq <= 1'b0;
      end else if ((raised[EVT_GOOD] && cfg[CFG_GOOD_IE]) // R07
                || (raised[EVT_CRC] && cfg[CFG_CRC_IE]) // R14
                || (raised[EVT_SHORT] && cfg[CFG_SHORT_IE]) // R15
                || (raised[EVT_OVER] && cfg[CFG_OVER_IE])) begin // R17
         interrupt_status_queue <= next_evt; // R21
         irq <= 1'b1; // R21
      end else if (reg_rd && reg_addr == ISQ_OFFSET) begin
         interrupt_status_queue <= '0;
         irq <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n)
         reg_rdata <= '0;
      else if (reg_rd) begin
         case (reg_addr)
            RX_CFG_OFFSET: reg_rdata <= cfg;
            RX_EVT_OFFSET: reg_rdata <= evt;
            ISQ_OFFSET:    reg_rdata <= interrupt_status_queue;
            default:       reg_rdata <= '0;
         endcase
      end
   end
endmodule

//--- verif/ercc_rx_cfg_properties.sv
`timescale 1ns/1ns
module ercc_rx_cfg_properties
   import ercc_pkg::*;
(
   // clock, reset, host port, frame side
   input wire logic                  mclk,
   input wire logic                  rst_n,
   input wire logic [15:0]           reg_addr,
   input wire logic                  reg_wr,
   input wire logic                  reg_rd,
   input wire logic [15:0]           reg_wdata,
   input wire logic [15:0]           reg_rdata,
   input wire ercc_pkg::ercc_frame_t frame,
   input wire ercc_pkg::ercc_route_t route,
   input wire logic                  skip_frame,
   input wire logic                  irq
);
   logic [15:0] c;
   logic        g;
   logic        sw;
   logic [10:0] fl;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   assign g  = frame.done && frame.length >= DISCARD_FRAME;
   assign sw = reg_wr && reg_addr == RX_CFG_OFFSET && reg_wdata[CFG_SKIP];
   assign fl = frame.length - CRC_BYTES;
   // shadow of the written configuration
   always_ff @(posedge mclk) begin
      if (!rst_n) c <= '0;
      else if (reg_wr && reg_addr == RX_CFG_OFFSET) c <= reg_wdata;
   end
   sequence s_pulse;
      skip_frame ##1 !skip_frame;
   endsequence
   a_skip_pulse: assert property (sw |=> s_pulse)
      else $error("skip pulse wrong");
   a_skip_cause: assert property (skip_frame |-> $past(sw))
      else $error("skip without write");
   a_tiny_drop: assert property (frame.done && !g |=> route.drop)
      else $error("tiny frame kept");
   a_dma_only: assert property (g && c[CFG_DMA_ONLY] |=> route.use_dma)
      else $error("dma not used");
   a_no_stream: assert property (g && !c[CFG_STREAM] |=> !route.use_stream)
      else $error("stream used");
   a_crc_len: assert property (g && !c[CFG_KEEP_CRC] ##1 route.deliver
      |-> route.length == $past(fl))
      else $error("length keeps crc");
   a_cfg_id: assert property (reg_rd && reg_addr == RX_CFG_OFFSET
      |=> reg_rdata[5:0] == RX_CFG_ID)
      else $error("id bits wrong");
   a_short_irq: assert property (g && frame.length < MIN_FRAME
      && c[CFG_SHORT_IE] |=> irq)
      else $error("short irq missing");
   a_over_irq: assert property (g && frame.length > MAX_FRAME
      && c[CFG_OVER_IE] |=> irq)
      else $error("oversize irq missing");
endmodule
bind ercc_rx_cfg ercc_rx_cfg_properties p_u(.mclk(mclk), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .frame(frame),
   .route(route), .skip_frame(skip_frame), .irq(irq));

//--- verif/ercc_host.sv
`timescale 1ns/1ns
module ercc_host (
   // host bus
   input  wire logic        mclk,
   input  wire logic [15:0] reg_rdata,
   output logic [15:0]      reg_addr,
   output logic             reg_wr,
   output logic             reg_rd,
   output logic [15:0]      reg_wdata
);
   initial {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
   task wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task rd(input logic [15:0] a, output logic [15:0] q);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask
endmodule

//--- verif/ercc_rx_cfg_tb.sv
`timescale 1ns/1ns
module ercc_rx_cfg_tb;
   import ercc_pkg::*;
   logic        mclk = 0, rst_n = 0, sk, irq, wr, rd;
   logic [15:0] a, w, r, q;
   logic        el = 1'b0;
   logic [15:0] ec = 16'h0000;
   ercc_frame_t fr = '0;
   ercc_route_t rt;
   int          n_errors = 0, n_checks = 0, cyc = 0;
   initial forever #4 mclk = ~mclk;
   ercc_host h_u(.mclk(mclk), .reg_rdata(r), .reg_addr(a), .reg_wr(wr),
      .reg_rd(rd), .reg_wdata(w));
   ercc_rx_cfg dut_u(.mclk(mclk), .rst_n(rst_n), .reg_addr(a), .reg_wr(wr),
      .reg_rd(rd), .reg_wdata(w), .reg_rdata(r), .eeprom_load(el),
      .eeprom_cfg(ec), .frame(fr), .route(rt), .skip_frame(sk),
      .irq(irq));
   task end_of_test;
      if (n_errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [15:0] s, input logic [15:0] e);
      n_checks++;
      if (s !== e) begin
         n_errors++;
         $display("unexpected %0h %h %h", $time, s, e);
      end
   endtask
   task rc(input logic [15:0] ad, input logic [15:0] e);
      h_u.rd(ad, q);
      chk(q, e);
   endtask
   // frame end report: length, then crc_bad, b2b, addr_pass, switch
   task fs(input logic [10:0] l, input logic [3:0] f);
      @(posedge mclk);
      fr <= {1'b1, l, f};
      @(posedge mclk);
      fr.done <= 1'b0;
      #1;
   endtask
   always @(posedge mclk) if (++cyc > 2000) begin
      n_errors++;
      end_of_test;
   end
   initial begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      rc(RX_CFG_OFFSET, 16'h0003);
      rc(RX_EVT_OFFSET, RX_EVT_RESET);
      h_u.wr(RX_CFG_OFFSET, 16'h707f);
      chk(sk, 1'b1);
      #8 chk(sk, 1'b0);
      rc(RX_CFG_OFFSET, 16'h7003);
      fs(11'd60, 4'h0);
      chk(irq, 1'b1);
      rc(RX_EVT_OFFSET, 16'h2004);
      rc(RX_EVT_OFFSET, 16'h0004);
      rc(ISQ_OFFSET, 16'h2004);
      chk(irq, 1'b0);
      fs(11'd7, 4'h0);
      chk(rt.drop, 1'b1);
      chk(irq, 1'b0);
      fs(11'd1600, 4'h8);
      rc(RX_EVT_OFFSET, 16'h5004);
      h_u.wr(RX_CFG_OFFSET, 16'h0900);
      h_u.rd(ISQ_OFFSET, q);
      fs(11'd100, 4'h0);
      chk(rt.length, 16'd100);
      chk(rt.deliver, 1'b1);
      chk(irq, 1'b1);
      h_u.rd(ISQ_OFFSET, q);
      h_u.wr(RX_CFG_OFFSET, 16'h0300);
      fs(11'd100, 4'h0);
      chk(rt.length, 16'd96);
      chk(rt.use_dma, 1'b1);
      chk(irq, 1'b0);
      h_u.wr(RX_CFG_OFFSET, 16'h0380);
      fs(11'd100, 4'h6);
      chk(rt.use_stream, 1'b1);
      h_u.wr(RX_CFG_OFFSET, 16'h0400);
      fs(11'd100, 4'h1);
      chk(rt.use_dma, 1'b1);
      h_u.wr(RX_CFG_OFFSET, 16'h0600);
      fs(11'd100, 4'h0);
      chk(rt.use_dma, 1'b1);
      @(posedge mclk);
      ec <= 16'h0840;
      el <= 1'b1;
      repeat (5) @(posedge mclk);
      el <= 1'b0;
      rc(RX_CFG_OFFSET, 16'h0803);
      end_of_test;
   end
endmodule
